// ==== rtl/sbl_ctrl.sv ====
// Serial EEPROM download and software byte access controller.
`timescale 1ns/1ns
// Behaviour
// - EEPROM device address fixed at 1010000.
// - Download starts when reset is released, if the present strap is high.
// - Load-active flag bit 4 during download.
// - Load-error flag bit 0 reports download result.
// - Four byte registers in doubleword B0h.
// - Buffer byte sends on write, receives on read, in addressed protocol only.
// - Word index sent only in addressed protocol and during download.
// - Protocol-select bit 7 picks addressed format.
// - Writing target byte launches a transaction.
// - Control byte shows present, busy, error, options.
// - Request-active held for the whole transfer.
// - Error and read byte valid at completion.
module sbl_ctrl
  import sbl_pkg::*;
#(
  parameter logic [7:0] LOAD_LAST = LOAD_LAST_WORD
)
(
  // Clock and synchronous reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Configuration space access.
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  // EEPROM-present strap; enables the download after reset.
  input  wire logic        present_pin,
  // Serial clock and data wires.
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // Downloaded bytes.
  output sbl_load_t        load
);

  sbl_state_t   st_q, st_d;
  sbl_eng_req_t req_q, req_d;
  sbl_eng_rsp_t rsp;
  sbl_load_t    load_q, load_d;
  logic [7:0]   buf_q, buf_d, word_q, word_d, tgt_q, tgt_d, lword_q, lword_d;
  logic         prot_q, prot_d, test_q, test_d, xerr_q, xerr_d;
  logic         lact_q, lact_d, lerr_q, lerr_d, ract_q, ract_d;
  logic         is_load_q, is_load_d, err_q, err_d, pend_q, pend_d;
  logic [1:0]   settle_q, settle_d;
  logic [31:0]  rdata_q, rdata_d;
  logic [15:0]  cnt_q, cnt_d;
  logic         tick_q, tick_d;
  logic [2:0]   meta_q, sync_q;
  logic         pin_low_q;
  logic         hit, quick, reading;

  // Builds a byte engine request.
  function automatic sbl_eng_req_t issue(sbl_eng_op_t op, logic [7:0] wd);
    sbl_eng_req_t r;
    r.go    = 1'b1;
    r.op    = op;
    r.wdata = wd;
    r.nack  = 1'b1;
    return r;
  endfunction

  // Control/status byte as software reads it.
  function automatic logic [7:0] ctl_byte(logic p, logic r, logic l,
                                          logic s, logic x, logic t,
                                          logic e);
    logic [7:0] c;
    c               = 8'h00;
    c[CTL_PROTOCOL_SELECT] = p;
    c[CTL_REQ_ACT]  = r;
    c[CTL_LOAD_ACT] = l;
    c[CTL_PRESENT]  = s;
    c[CTL_XFER_ERR] = x;
    c[CTL_BUS_TEST] = t;
    c[CTL_LOAD_ERR] = e;
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for present strap, clock and data wires.
  always_ff @(posedge sys_clk)
  begin
    meta_q    <= {present_pin, scl_in, sda_in};
    sync_q    <= meta_q;
    pin_low_q <= 1'b0;
  end

  // Quarter-bit divider; the bus test bit runs it at full clock rate.
  always_comb
  begin
    tick_d = 1'b0;
    cnt_d  = cnt_q - 16'h1;
    if (cnt_q == 16'h0 || test_q)
    begin
      cnt_d  = QTR_CYCLES - 16'h1;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cnt_q  <= 16'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  sbl_byte_eng u_eng (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .tick      (tick_q),
    .scl_level (sync_q[1]),
    .sda_level (sync_q[0]),
    .req       (req_q),
    .rsp       (rsp),
    .scl_oe_n  (scl_oe_n),
    .sda_oe_n  (sda_oe_n)
  );

  assign hit     = cfg_addr[7:2] == CFG_DWORD_OFS[7:2];
  assign quick   = !is_load_q && !prot_q;
  assign reading = is_load_q || tgt_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Registers, launch and transaction sequencer.
  always_comb
  begin
    st_d = st_q;  req_d = '0;  load_d = '0;
    buf_d = buf_q;  word_d = word_q;  tgt_d = tgt_q;  lword_d = lword_q;
    prot_d = prot_q;  test_d = test_q;  xerr_d = xerr_q;
    lact_d = lact_q;  lerr_d = lerr_q;  ract_d = ract_q;
    is_load_d = is_load_q;  err_d = err_q;  pend_d = pend_q;
    settle_d = (settle_q == 2'h0) ? settle_q : settle_q - 2'h1;
    rdata_d = 32'h0;
    // Software reads and writes of the doubleword.
    if (cfg_rd && hit)
      rdata_d = {ctl_byte(prot_q, ract_q, lact_q, sync_q[2], xerr_q,
                          test_q, lerr_q), tgt_q, word_q, buf_q};
    if (cfg_wr && hit)
    begin
      if (cfg_be[0] && !ract_q)
        buf_d = cfg_wdata[7:0];
      if (cfg_be[1] && !ract_q)
        word_d = cfg_wdata[15:8];
      if (cfg_be[3])
      begin
        prot_d = cfg_wdata[24 + CTL_PROTOCOL_SELECT];
        test_d = cfg_wdata[24 + CTL_BUS_TEST];
        if (cfg_wdata[24 + CTL_XFER_ERR])
          xerr_d = 1'b0;
      end
    end
    case (st_q)
      ST_IDLE:
      begin
        if (pend_q && settle_q == 2'h0)
        begin
          pend_d = 1'b0;
          if (sync_q[2])
          begin
            lact_d = 1'b1;
            lerr_d = 1'b0;
            is_load_d = 1'b1;
            err_d = 1'b0;
            lword_d = LOAD_FIRST_WORD;
            st_d = ST_START;
            req_d = issue(ENG_START, 8'h00);
          end
        end
        else if (!pend_q && cfg_wr && hit && cfg_be[2])
        begin
          tgt_d = cfg_wdata[23:16];
          ract_d = 1'b1;
          is_load_d = 1'b0;
          err_d = 1'b0;
          st_d = ST_START;
          req_d = issue(ENG_START, 8'h00);
        end
      end
      ST_START:
        if (rsp.done)
        begin
          st_d = ST_DEVW;
          if (is_load_q)
            req_d = issue(ENG_WRITE, {EEPROM_DEV_ADDR, 1'b0});
          else if (quick)
            req_d = issue(ENG_WRITE, tgt_q);
          else
            req_d = issue(ENG_WRITE, {tgt_q[7:1], 1'b0});
        end
      ST_DEVW:
        if (rsp.done)
        begin
          if (!rsp.ack || quick)
          begin
            err_d = !rsp.ack;
            st_d = ST_STOP;
            req_d = issue(ENG_STOP, 8'h00);
          end
          else
          begin
            st_d = ST_WORD;
            req_d = issue(ENG_WRITE, is_load_q ? lword_q : word_q);
          end
        end
      ST_WORD:
        if (rsp.done)
        begin
          if (!rsp.ack)
          begin
            err_d = 1'b1;
            st_d = ST_STOP;
            req_d = issue(ENG_STOP, 8'h00);
          end
          else if (reading)
          begin
            st_d = ST_RSTART;
            req_d = issue(ENG_START, 8'h00);
          end
          else
          begin
            st_d = ST_DATA;
            req_d = issue(ENG_WRITE, buf_q);
          end
        end
      ST_DATA:
        if (rsp.done)
        begin
          err_d = !rsp.ack;
          st_d = ST_STOP;
          req_d = issue(ENG_STOP, 8'h00);
        end
      ST_RSTART:
        if (rsp.done)
        begin
          st_d = ST_DEVR;
          req_d = issue(ENG_WRITE, is_load_q ? {EEPROM_DEV_ADDR, 1'b1}
                                             : {tgt_q[7:1], 1'b1});
        end
      ST_DEVR:
        if (rsp.done)
        begin
          st_d = ST_STOP;
          if (!rsp.ack)
          begin
            err_d = 1'b1;
            req_d = issue(ENG_STOP, 8'h00);
          end
          else
          begin
            st_d = ST_READ;
            req_d = issue(ENG_READ, 8'h00);
          end
        end
      ST_READ:
        if (rsp.done)
        begin
          if (is_load_q)
            load_d = '{we: 1'b1, addr: lword_q, data: rsp.rdata};
          else
            buf_d = rsp.rdata;
          st_d = ST_STOP;
          req_d = issue(ENG_STOP, 8'h00);
        end
      ST_STOP:
        if (rsp.done)
        begin
          st_d = ST_IDLE;
          if (!is_load_q)
          begin
            ract_d = 1'b0;
            if (err_q)
              xerr_d = 1'b1;
          end
          else if (!err_q && lword_q != LOAD_LAST)
          begin
            lword_d = lword_q + 8'h01;
            st_d = ST_START;
            req_d = issue(ENG_START, 8'h00);
          end
          else
          begin
            lact_d = 1'b0;
            lerr_d = err_q;
          end
        end
      default:
        st_d = ST_IDLE;
    endcase
  end

  // Register stage for sequencer, flags and configuration bytes.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q <= ST_IDLE;  req_q <= '0;  load_q <= '0;
      buf_q <= BYTE_RST;  word_q <= BYTE_RST;  tgt_q <= BYTE_RST;
      lword_q <= BYTE_RST;  prot_q <= 1'b0;  test_q <= 1'b0;
      xerr_q <= 1'b0;  lact_q <= 1'b0;  lerr_q <= 1'b0;  ract_q <= 1'b0;
      is_load_q <= 1'b0;  err_q <= 1'b0;  pend_q <= 1'b1;
      settle_q <= SETTLE_CYCLES;  rdata_q <= 32'h0;
    end
    else
    begin
      st_q <= st_d;  req_q <= req_d;  load_q <= load_d;
      buf_q <= buf_d;  word_q <= word_d;  tgt_q <= tgt_d;
      lword_q <= lword_d;  prot_q <= prot_d;  test_q <= test_d;
      xerr_q <= xerr_d;  lact_q <= lact_d;  lerr_q <= lerr_d;
      ract_q <= ract_d;  is_load_q <= is_load_d;  err_q <= err_d;
      pend_q <= pend_d;  settle_q <= settle_d;  rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = rdata_q;
  assign load      = load_q;
  assign scl_out   = pin_low_q;
  assign sda_out   = pin_low_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer.
  a_dev_addr_fixed: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (req_q.go && is_load_q && (st_q == ST_DEVW || st_q == ST_DEVR)) |->
    req_q.wdata[7:1] == EEPROM_DEV_ADDR)
    else $error("download used a wrong device address");
  a_load_starts: assert property (@(posedge sys_clk)
    $fell(sys_rst) |-> ##[1:5] !pend_q)
    else $error("download did not start after reset release");
  a_load_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (is_load_q && st_q != ST_IDLE) |-> lact_q)
    else $error("load-active flag low during download");
  a_load_result: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(lact_q) |-> lerr_q == $past(err_q))
    else $error("load-error flag does not match the outcome");
  a_status_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfg_rd && hit) |=> cfg_rdata[15:0] == {$past(word_q), $past(buf_q)})
    else $error("doubleword read returned wrong bytes");
  a_read_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_q == ST_READ && rsp.done && !is_load_q) |=> buf_q == $past(rsp.rdata))
    else $error("received byte not placed in buffer");
  a_quick_skip: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_q == ST_DEVW && rsp.done && quick) |=> st_q == ST_STOP)
    else $error("quick command sent a word index");
  a_launch_busy: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_q == ST_IDLE && !pend_q && cfg_wr && hit && cfg_be[2])
    |=> ract_q ##1 st_q == ST_START)
    else $error("target write did not launch a transfer");
  a_busy_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(ract_q) |-> $past(st_q) == ST_STOP && st_q == ST_IDLE)
    else $error("request-active dropped before the stop");
  a_nack_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rsp.done && !rsp.ack && (st_q == ST_DEVW || st_q == ST_WORD ||
     st_q == ST_DEVR)) |=> st_q == ST_STOP && err_q && req_q.op == ENG_STOP)
    else $error("missing acknowledge not handled");

endmodule

// ==== rtl/sbl_pkg.sv ====
// Shared constants and types for the serial EEPROM loader and access port.
package sbl_pkg;

  // Clock rate and serial bit time; quarter-bit count derives from both.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BIT_TIME_NS   = 10000;
  localparam int unsigned QTR_CYC_INT   =
    (BIT_TIME_NS / (4 * CLK_PERIOD_NS) < 1) ? 1 :
    BIT_TIME_NS / (4 * CLK_PERIOD_NS);
  localparam logic [15:0] QTR_CYCLES    = QTR_CYC_INT[15:0];

  // Configuration doubleword and its four byte registers.
  localparam logic [7:0] CFG_DWORD_OFS  = 8'hB0;
  localparam logic [7:0] REG_BUFFER_OFS = 8'hB0;
  localparam logic [7:0] REG_WORD_OFS   = 8'hB1;
  localparam logic [7:0] REG_TARGET_OFS = 8'hB2;
  localparam logic [7:0] REG_CTRL_OFS   = 8'hB3;

  // Bit positions inside the control/status byte.
  localparam int unsigned CTL_PROTOCOL_SELECT  = 7;
  localparam int unsigned CTL_REQ_ACT   = 5;
  localparam int unsigned CTL_LOAD_ACT  = 4;
  localparam int unsigned CTL_PRESENT   = 3;
  localparam int unsigned CTL_XFER_ERR  = 2;
  localparam int unsigned CTL_BUS_TEST  = 1;
  localparam int unsigned CTL_LOAD_ERR  = 0;

  // Fixed device address of the initialization memory.
  localparam logic [6:0] EEPROM_DEV_ADDR = 7'h50;

  // Word range read by the automatic download.
  localparam logic [7:0] LOAD_FIRST_WORD = 8'h00;
  localparam logic [7:0] LOAD_LAST_WORD  = 8'h3A;

  // Values after reset.
  localparam logic [7:0] BYTE_RST        = 8'h00;
  localparam logic [1:0] SETTLE_CYCLES   = 2'h3;

  // Primitive operations of the byte engine.
  typedef enum logic [1:0] {
    ENG_START = 2'b00,
    ENG_STOP  = 2'b01,
    ENG_WRITE = 2'b10,
    ENG_READ  = 2'b11
  } sbl_eng_op_t;

  // Request into the byte engine.
  typedef struct packed {
    logic        go;
    sbl_eng_op_t op;
    logic [7:0]  wdata;
    logic        nack;
  } sbl_eng_req_t;

  // Answer from the byte engine.
  typedef struct packed {
    logic       done;
    logic       ack;
    logic [7:0] rdata;
  } sbl_eng_rsp_t;

  // One downloaded byte towards the configuration registers.
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } sbl_load_t;

  // Transaction sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_START  = 4'b0001,
    ST_DEVW   = 4'b0010,
    ST_WORD   = 4'b0011,
    ST_DATA   = 4'b0100,
    ST_RSTART = 4'b0101,
    ST_DEVR   = 4'b0110,
    ST_READ   = 4'b0111,
    ST_STOP   = 4'b1000
  } sbl_state_t;

endpackage

// ==== rtl/sbl_byte_eng.sv ====
// Bit-level engine: start, stop, byte write and byte read on the wires.
`timescale 1ns/1ns
module sbl_byte_eng
  import sbl_pkg::*;
(
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // Quarter-bit enable and synchronised wire levels.
  input  wire logic         tick,
  input  wire logic         scl_level,
  input  wire logic         sda_level,
  // Operation request and answer.
  input  wire sbl_eng_req_t req,
  output sbl_eng_rsp_t      rsp,
  // Open-drain enables, low while pulling the wire low.
  output logic              scl_oe_n,
  output logic              sda_oe_n
);

  logic         busy_q, busy_d;
  sbl_eng_op_t  op_q, op_d;
  logic [1:0]   ph_q, ph_d;
  logic [3:0]   bit_q, bit_d;
  logic [8:0]   sh_q, sh_d;
  sbl_eng_rsp_t rsp_q, rsp_d;
  logic         scl_q, scl_d;
  logic         sda_q, sda_d;
  logic         advance;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic; a slave holding the clock low stalls phase two.
  always_comb
  begin
    busy_d   = busy_q;
    op_d     = op_q;
    ph_d     = ph_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    scl_d    = scl_q;
    sda_d    = sda_q;
    rsp_d    = rsp_q;
    rsp_d.done = 1'b0;
    advance  = tick && !(ph_q == 2'h2 && scl_q && !scl_level);
    if (!busy_q)
    begin
      if (req.go)
      begin
        busy_d = 1'b1;
        op_d   = req.op;
        ph_d   = 2'h0;
        bit_d  = 4'h0;
        sh_d   = (req.op == ENG_READ) ? {8'hFF, req.nack}
                                      : {req.wdata, 1'b1};
      end
    end
    else if (advance)
    begin
      ph_d = ph_q + 2'h1;
      case (op_q)
        ENG_START:
        begin
          case (ph_q)
            2'h0: sda_d = 1'b1;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b0;
            default:
            begin
              scl_d      = 1'b0;
              busy_d     = 1'b0;
              rsp_d.done = 1'b1;
            end
          endcase
        end
        ENG_STOP:
        begin
          case (ph_q)
            2'h0: sda_d = 1'b0;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b1;
            default:
            begin
              busy_d     = 1'b0;
              rsp_d.done = 1'b1;
            end
          endcase
        end
        default:
        begin
          case (ph_q)
            2'h0: sda_d = sh_q[8];
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = sda_q;
            default:
            begin
              scl_d = 1'b0;
              sh_d  = {sh_q[7:0], sda_level};
              bit_d = bit_q + 4'h1;
              if (bit_q == 4'h8)
              begin
                busy_d      = 1'b0;
                rsp_d.done  = 1'b1;
                rsp_d.ack   = !sda_level;
                rsp_d.rdata = sh_q[7:0];
              end
            end
          endcase
        end
      endcase
    end
  end

  // State registers; both wires rest released.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      op_q   <= ENG_START;
      ph_q   <= 2'h0;
      bit_q  <= 4'h0;
      sh_q   <= 9'h1FF;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      rsp_q  <= '0;
    end
    else
    begin
      busy_q <= busy_d;
      op_q   <= op_d;
      ph_q   <= ph_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      scl_q  <= scl_d;
      sda_q  <= sda_d;
      rsp_q  <= rsp_d;
    end
  end

  assign rsp      = rsp_q;
  assign scl_oe_n = scl_q;
  assign sda_oe_n = sda_q;

endmodule

// ==== tb/sbl_eeprom_model.sv ====
// Behavioural two-wire memory slave facing the serial controller.
`timescale 1ns/1ns
module sbl_eeprom_model #(
  parameter logic [6:0] DEV = 7'h50
)
(
  // Resolved wire levels.
  input  wire logic scl,
  input  wire logic sda,
  // Data pull enable, low while pulling the wire low.
  output logic      sda_oe_n
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic       act;
  logic       rdir;
  int         bc;
  int         ph;
  int         nbyte;
  //////////////////////////////////////////////////////////////////////////
  // Contents follow a pattern that the bench predicts.
  initial
  begin
    sda_oe_n = 1'h1;
    act = 1'h0;
    ph = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ 8'h5A;
  end
  // A start restarts framing; a stop ends it.
  always @(negedge sda)
    if (scl === 1'h1)
    begin
      act = 1'h1;
      ph = 0;
      bc = 0;
      nbyte = 0;
    end
  always @(posedge sda)
    if (scl === 1'h1)
      act = 1'h0;
  // Master bits are taken while the clock is high.
  always @(posedge scl)
    if (act && ph == 0)
    begin
      sh = {sh[6:0], sda};
      bc = bc + 1;
    end
  // Acknowledge, read data and release change only while the clock is low.
  always @(negedge scl)
    if (act)
      case (ph)
        0:
        if (bc == 8)
        begin
          if (nbyte == 0)
            rdir = sh[0];
          if (nbyte == 0)
            act = (sh[7:1] == DEV);
          else if (nbyte == 1)
            ptr = sh;
          else
          begin
            mem[ptr] = sh;
            ptr = ptr + 8'h01;
          end
          nbyte = nbyte + 1;
          sda_oe_n = !act;
          ph = 1;
        end
        1:
        begin
          bc = rdir ? 1 : 0;
          sda_oe_n = rdir ? mem[ptr][7] : 1'h1;
          ph = rdir ? 2 : 0;
        end
        2:
        begin
          sda_oe_n = (bc == 8) ? 1'h1 : mem[ptr][7 - bc];
          ph = (bc == 8) ? 3 : 2;
          bc = bc + 1;
        end
        default:
          act = 1'h0;
      endcase
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the serial EEPROM loader and access port.
`timescale 1ns/1ns
module tb
  import sbl_pkg::*;
;
  logic        sys_clk;
  logic        sys_rst;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        present_pin;
  logic        scl_out;
  logic        scl_oe_n;
  logic        sda_out;
  logic        sda_oe_n;
  logic        m_oe_n;
  sbl_load_t   load;
  logic [7:0]  ref_mem [256];
  logic [7:0]  v;
  logic [7:0]  w;
  logic [7:0]  d;
  int          failures;
  int          n_compared;
  int          nld;
  // Pulled-up wires resolve as the AND of all drivers.
  wire scl_w = scl_oe_n ? 1'h1 : scl_out;
  wire sda_w = (sda_oe_n ? 1'h1 : sda_out) & m_oe_n;

  sbl_ctrl #(
    .LOAD_LAST (8'h01)
  ) u_dut (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .cfg_wr      (cfg_wr),
    .cfg_rd      (cfg_rd),
    .cfg_addr    (cfg_addr),
    .cfg_be      (cfg_be),
    .cfg_wdata   (cfg_wdata),
    .cfg_rdata   (cfg_rdata),
    .present_pin (present_pin),
    .scl_in      (scl_w),
    .scl_out     (scl_out),
    .scl_oe_n    (scl_oe_n),
    .sda_in      (sda_w),
    .sda_out     (sda_out),
    .sda_oe_n    (sda_oe_n),
    .load        (load)
  );
  sbl_eeprom_model m (
    .scl      (scl_w),
    .sda      (sda_w),
    .sda_oe_n (m_oe_n)
  );
  //////////////////////////////////////////////////////////////////////////
  // Clock of 50 ns period.
  initial
    sys_clk = 1'h0;
  always #25 sys_clk = ~sys_clk;

  task automatic finish_test;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-lane configuration write and read.
  task automatic wr(input logic [1:0] ln, input logic [7:0] val);
    @(posedge sys_clk);
    cfg_wr <= 1'h1;
    cfg_be <= 4'h1 << ln;
    cfg_wdata <= {4{val}};
    @(posedge sys_clk);
    cfg_wr <= 1'h0;
    cfg_be <= 4'h0;
  endtask

  task automatic rd(input logic [1:0] ln, output logic [7:0] val);
    @(posedge sys_clk);
    cfg_rd <= 1'h1;
    @(posedge sys_clk);
    cfg_rd <= 1'h0;
    #1;
    val = cfg_rdata[ln*8 +: 8];
  endtask

  // Polls a status bit of the control byte until it drops.
  task automatic wait_clear(input int b);
    logic [7:0] s;
    s = 8'hFF;
    for (int i = 0; i < 20000 && s[b] === 1'h1; i++)
      rd(2'h3, s);
    check({7'h00, s[b]}, 8'h00);
  endtask

  // Every downloaded byte is compared with the memory pattern.
  always @(negedge sys_clk)
    if (load.we === 1'h1)
    begin
      check(load.data, ref_mem[nld]);
      nld = nld + 1;
    end

  // Watchdog well past the expected run length.
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    finish_test;
  end

  // Main sequence.
  initial
  begin
    {sys_rst, present_pin} = 2'h3;
    {cfg_wr, cfg_rd, cfg_be, cfg_wdata} = '0;
    cfg_addr = 8'hB0;
    {failures, n_compared, nld} = '0;
    for (int i = 0; i < 256; i++)
      ref_mem[i] = i[7:0] ^ 8'h5A;
    void'($urandom(32'h1DB98303));
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'h0;
    repeat (8) @(posedge sys_clk);
    rd(2'h3, v);
    check(v & 8'h18, 8'h18);
    wait_clear(4);
    check(nld[7:0], 8'h02);
    rd(2'h3, v);
    check(v, 8'h08);
    wr(2'h3, 8'hFF);
    rd(2'h3, v);
    check(v, 8'h8A);
    wr(2'h3, 8'h80);
    cfg_addr <= 8'hB4;
    rd(2'h0, v);
    check(v, 8'h00);
    @(posedge sys_clk);
    cfg_addr <= 8'hB0;
    for (int k = 0; k < 2; k++)
    begin
      w = 8'($urandom);
      d = 8'($urandom);
      rd(2'h3, v);
      check(v & 8'h3C, 8'h08);
      wr(2'h1, w);
      wr(2'h0, d);
      wr(2'h2, {7'h50, 1'h0});
      rd(2'h3, v);
      check(v & 8'h20, 8'h20);
      wait_clear(5);
      ref_mem[w] = d;
      check(m.mem[w], ref_mem[w]);
      wr(2'h2, {7'h50, 1'h1});
      wr(2'h1, ~w);
      wait_clear(5);
      rd(2'h0, v);
      check(v, ref_mem[w]);
      rd(2'h1, v);
      check(v, w);
    end
    wr(2'h3, 8'h00);
    wr(2'h2, {7'h50, 1'h0});
    wait_clear(5);
    check(m.nbyte[7:0], 8'h01);
    rd(2'h3, v);
    check(v, 8'h08);
    wr(2'h3, 8'h80);
    wr(2'h2, {7'h51, 1'h1});
    wait_clear(5);
    rd(2'h3, v);
    check(v, 8'h8C);
    wr(2'h3, 8'h84);
    rd(2'h3, v);
    check(v, 8'h88);
    // Second reset with the strap low: no download, nothing present.
    @(posedge sys_clk);
    present_pin <= 1'h0;
    sys_rst <= 1'h1;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'h0;
    repeat (8) @(posedge sys_clk);
    rd(2'h3, v);
    check(v, 8'h00);
    check(nld[7:0], 8'h02);
    finish_test;
  end
endmodule
